// ==== rtl/ulc_link.sv ====
`timescale 1ns/10ps
module ulc_link
	import ulc_pkg::*;
#(
	parameter int W = TIMER_W,
	parameter int SUSP_IDLE = SUSP_IDLE_CYC,
	parameter int HOST_RESUME = HOST_RESUME_CYC,
	parameter int RWAKE_DRIVE = RWAKE_DRIVE_CYC
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ulpi_dir,
	input wire logic ulpi_nxt,
	input wire logic [7:0] ulpi_data_in,
	output logic ulpi_stp,
	output logic [7:0] ulpi_data_out,
	output logic ulpi_data_oe,
	input wire logic role_periph,
	input wire logic host_powerdown,
	input wire logic serial_en,
	input wire logic nopid_en,
	input wire logic suspend_req,
	input wire logic resume_req,
	input wire logic remote_wake_req,
	input wire logic tx_start,
	input wire logic [7:0] tx_len,
	input wire logic [7:0] tx_data,
	input wire logic [7:0] tx_eop_code,
	output logic [7:0] tx_idx,
	output logic tx_done,
	output logic busy,
	output logic suspended,
	output logic [1:0] line_state,
	output logic id_level,
	output logic id_changed,
	output logic [1:0] vbus_state,
	output logic vbus_changed
);

	typedef struct packed {
		ulc_state_e state;
		ulc_state_e ret;
		logic [5:0] wr_addr;
		logic [7:0] wr_data;
		logic [7:0] func;
		logic serial;
		logic stp;
		logic [7:0] dout;
		logic oe;
		logic [1:0] ls;
		logic was_hs;
		logic lowpower;
		logic rwk;
		logic cmd_sent;
		logic [7:0] idx;
		logic tx_done;
		logic tload;
		logic [W-1:0] tval;
	} ulc_st_s;

	ulc_st_s st_reg;
	ulc_st_s st_next;
	logic [1:0] rx_ls;
	logic tmr_done;
	logic [7:0] otg_val;

	// starts a register write, then continues at ret
	function automatic ulc_st_s go_wr(ulc_st_s s, logic [5:0] a,
		logic [7:0] d, ulc_state_e r);
		ulc_st_s t;
		t = s;
		t.wr_addr = a;
		t.wr_data = d;
		t.ret = r;
		t.state = ST_WCMD;
		return t;
	endfunction : go_wr

	// loads the shared timer with a cycle count
	function automatic ulc_st_s go_tmr(ulc_st_s s, int cyc);
		ulc_st_s t;
		t = s;
		t.tload = 1'b1;
		t.tval = W'(cyc);
		return t;
	endfunction : go_tmr

	ulc_rxcmd u_rx (
		.core_clk(core_clk),
		.resetn(resetn),
		.ulpi_dir(ulpi_dir),
		.ulpi_nxt(ulpi_nxt),
		.ulpi_data_in(ulpi_data_in),
		.line_state(rx_ls),
		.id_level(id_level),
		.id_changed(id_changed),
		.vbus_state(vbus_state),
		.vbus_changed(vbus_changed)
	);

	ulc_timer #(.W(W)) u_tmr (
		.core_clk(core_clk),
		.resetn(resetn),
		.load(st_reg.tload),
		.value(st_reg.tval),
		.done(tmr_done)
	);

	// id pull-up always on; a host also enables both pull-downs
	always_comb
	begin
		otg_val = 8'h00;
		otg_val[OTG_IDPU_BIT] = 1'b1;
		otg_val[OTG_DPPD_BIT] = !role_periph;
		otg_val[OTG_DMPD_BIT] = !role_periph;
	end

	// link sequencer: register writes, suspend, resume, packets
	always_comb
	begin
		st_next = st_reg;
		st_next.tload = 1'b0;
		st_next.tx_done = 1'b0;
		st_next.stp = 1'b0;
		// bus is ours only while the phy leaves dir low
		st_next.oe = !ulpi_dir;
		st_next.ls = rx_ls;
		case (st_reg.state)
			ST_INIT:
				st_next = go_wr(st_next, ADDR_OTG, otg_val, ST_HSOPM);
			ST_IDLE:
			begin
				st_next.dout = DATA_IDLE;
				if (ulpi_dir)
				begin
					// any received traffic counts as bus activity
					if (role_periph)
						st_next = go_tmr(st_next, SUSP_IDLE);
				end
				else if (serial_en != st_reg.serial)
				begin
					st_next.serial = serial_en;
					st_next = go_wr(st_next, ADDR_INTF,
						8'(serial_en) << INTF_SERIAL3_BIT, ST_IDLE);
				end
				else if ((!role_periph && suspend_req) ||
					(role_periph && tmr_done))
				begin
					// remember the speed for the way back out
					st_next.was_hs =
						st_reg.func[FUNC_XCVR_LSB +: 2] == XCVR_HS;
					st_next.func = ulc_func(XCVR_FS, 1'b1, OPM_NORMAL, 1'b1);
					st_next = go_wr(st_next, ADDR_FUNC, st_next.func,
						ST_LPW);
				end
				else if (st_reg.func[FUNC_XCVR_LSB +: 2] == XCVR_HS &&
					nopid_en != (st_reg.func[FUNC_OPM_LSB +: 2] ==
					OPM_NO_SYNC_EOP))
				begin
					st_next.func = ulc_func(XCVR_HS, 1'b0,
						nopid_en ? OPM_NO_SYNC_EOP : OPM_NORMAL, 1'b1);
					st_next = go_wr(st_next, ADDR_FUNC, st_next.func, ST_IDLE);
				end
				else if (tx_start &&
					st_reg.func[FUNC_OPM_LSB +: 2] == OPM_NO_SYNC_EOP)
				begin
					st_next.state = ST_PKT;
					st_next.dout = TXCMD_NOPID;
					st_next.cmd_sent = 1'b0;
					st_next.idx = 8'h00;
				end
			end
			ST_WCMD:
			begin
				st_next.dout = {TXCMD_REGWR, st_reg.wr_addr};
				if (!ulpi_dir && ulpi_nxt && st_reg.oe)
				begin
					st_next.dout = st_reg.wr_data;
					st_next.state = ST_WDAT;
				end
			end
			ST_WDAT:
			begin
				// the phy took the bus back: start the write over
				if (ulpi_dir)
					st_next.state = ST_WCMD;
				else if (ulpi_nxt)
				begin
					st_next.stp = 1'b1;
					st_next.dout = DATA_IDLE;
					st_next.state = ST_WSTP;
				end
			end
			ST_WSTP:
			begin
				st_next.state = st_reg.ret;
				if (role_periph && st_reg.ret == ST_IDLE)
					st_next = go_tmr(st_next, SUSP_IDLE);
			end
			ST_LPW:
			begin
				st_next.rwk = 1'b0;
				st_next.lowpower = role_periph || host_powerdown;
				if (role_periph || host_powerdown)
				begin
					// clearing suspendm drops the phy into low power
					st_next.func = ulc_func(XCVR_FS, 1'b1, OPM_NORMAL, 1'b0);
					st_next = go_wr(st_next, ADDR_FUNC, st_next.func,
						ST_SUSP);
				end
				else
					st_next.state = ST_SUSP;
			end
			ST_SUSP:
			begin
				if (!role_periph && (resume_req ||
					st_reg.ls == LS_RESUME_K))
					st_next.state = st_reg.lowpower ? ST_WAKE : ST_RWK;
				else if (role_periph && st_reg.ls == LS_RESUME_K)
					st_next.state = ST_WAKE;
				else if (role_periph && remote_wake_req)
				begin
					st_next.rwk = 1'b1;
					st_next.state = ST_WAKE;
				end
			end
			ST_WAKE:
			begin
				// hold stp until the phy hands the bus back
				st_next.stp = ulpi_dir;
				if (!ulpi_dir && !st_reg.stp)
				begin
					st_next.lowpower = 1'b0;
					st_next.func[FUNC_SUSPM_BIT] = 1'b1;
					st_next.state = ST_RWK;
				end
			end
			ST_RWK:
			begin
				if (!role_periph || st_reg.rwk)
				begin
					// resume k only ever goes out with opmode 10b
					st_next.func = ulc_func(XCVR_FS, 1'b1, OPM_NO_BITSTUFF,
						1'b1);
					st_next.cmd_sent = 1'b0;
					st_next = go_wr(st_next, ADDR_FUNC, st_next.func, ST_TXK);
				end
				else
					st_next.state = ST_WSE0;
			end
			ST_TXK:
			begin
				st_next.dout = st_reg.cmd_sent ? DATA_IDLE : TXCMD_NOPID;
				if (role_periph)
					st_next.ls = LS_TX_K;
				if (!st_reg.cmd_sent && ulpi_nxt && !ulpi_dir)
				begin
					st_next.cmd_sent = 1'b1;
					st_next.dout = DATA_IDLE;
					st_next = go_tmr(st_next,
						role_periph ? RWAKE_DRIVE : HOST_RESUME);
				end
				else if (st_reg.cmd_sent && tmr_done)
				begin
					// stp ends the k; for a host the phy then appends the eop
					st_next.stp = 1'b1;
					st_next.state = ST_TXKSTP;
				end
			end
			ST_TXKSTP:
				st_next.state = ST_WSE0;
			ST_WSE0:
			begin
				// speed must be back before the eop se0 ends
				if (st_reg.ls == LS_SE0 && !ulpi_dir)
				begin
					st_next.func = st_reg.was_hs ?
						ulc_func(XCVR_HS, 1'b0, st_reg.func[FUNC_OPM_LSB +: 2],
						1'b1) : ulc_func(XCVR_FS, 1'b1, OPM_NORMAL, 1'b1);
					st_next = go_wr(st_next, ADDR_FUNC, st_next.func,
						st_reg.was_hs ? ST_HSOPM : ST_IDLE);
				end
			end
			ST_HSOPM:
			begin
				st_next.was_hs = 1'b0;
				st_next.func = ulc_func(XCVR_HS, 1'b0, OPM_NORMAL, 1'b1);
				st_next = go_wr(st_next, ADDR_FUNC, st_next.func,
					ST_IDLE);
			end
			ST_PKT:
			begin
				// tx_data answers for tx_idx in the same cycle
				if (ulpi_dir)
				begin
					st_next.dout = DATA_IDLE;
					st_next.tx_done = 1'b1;
					st_next.state = ST_IDLE;
				end
				else if (ulpi_nxt && st_reg.oe)
				begin
					st_next.cmd_sent = 1'b1;
					if (st_reg.cmd_sent && st_reg.idx == tx_len)
					begin
						// feh: unstuffed eop, 00h: no eop at all
						st_next.stp = 1'b1;
						st_next.dout = tx_eop_code;
						st_next.state = ST_PKTSTP;
					end
					else
					begin
						st_next.dout = tx_data;
						st_next.idx = st_reg.idx + 8'h01;
					end
				end
			end
			ST_PKTSTP:
			begin
				st_next.dout = DATA_IDLE;
				st_next.tx_done = 1'b1;
				st_next.state = ST_IDLE;
			end
			default:
				st_next.state = ST_INIT;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// outputs come from flops; busy and suspended are decoded from the state flops
	assign ulpi_stp = st_reg.stp;
	assign ulpi_data_out = st_reg.dout;
	assign ulpi_data_oe = st_reg.oe;
	assign tx_idx = st_reg.idx;
	assign tx_done = st_reg.tx_done;
	assign busy = st_reg.state != ST_IDLE;
	assign suspended = st_reg.state == ST_SUSP;
	assign line_state = st_reg.ls;

endmodule : ulc_link

// ==== rtl/ulc_pkg.sv ====
package ulc_pkg;

	// clock and protocol timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int SUSP_IDLE_MS = 3;
	localparam int HOST_RESUME_MS = 20;
	localparam int RWAKE_DRIVE_MS = 2;
	localparam int NS_PER_MS = 1_000_000;
	// least times, rounded up to whole cycles
	localparam int SUSP_IDLE_CYC =
		(SUSP_IDLE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_RESUME_CYC =
		(HOST_RESUME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RWAKE_DRIVE_CYC =
		(RWAKE_DRIVE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 24;

	// phy register addresses
	localparam logic [5:0] ADDR_FUNC = 6'h04;
	localparam logic [5:0] ADDR_INTF = 6'h07;
	localparam logic [5:0] ADDR_OTG = 6'h0a;

	// function control fields
	localparam int FUNC_XCVR_LSB = 0;
	localparam int FUNC_TERM_BIT = 2;
	localparam int FUNC_OPM_LSB = 3;
	localparam int FUNC_SUSPM_BIT = 6;
	localparam logic [1:0] XCVR_HS = 2'h0;
	localparam logic [1:0] XCVR_FS = 2'h1;
	localparam logic [1:0] OPM_NORMAL = 2'h0;
	localparam logic [1:0] OPM_NO_BITSTUFF = 2'h2;
	localparam logic [1:0] OPM_NO_SYNC_EOP = 2'h3;

	// otg and interface control bits
	localparam int OTG_IDPU_BIT = 0;
	localparam int OTG_DPPD_BIT = 1;
	localparam int OTG_DMPD_BIT = 2;
	localparam int INTF_SERIAL3_BIT = 1;

	// ulpi command bytes
	localparam logic [7:0] TXCMD_NOPID = 8'h40;
	localparam logic [1:0] TXCMD_REGWR = 2'h2;
	localparam logic [7:0] DATA_IDLE = 8'h00;

	// rxcmd fields and line states
	localparam int RX_LS_LSB = 0;
	localparam int RX_VBUS_LSB = 2;
	localparam int RX_ID_BIT = 6;
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_TX_K = 2'h1;
	localparam logic [1:0] LS_RESUME_K = 2'h2;

	typedef enum logic [3:0] {
		ST_INIT = 4'b0000,
		ST_IDLE = 4'b0001,
		ST_WCMD = 4'b0010,
		ST_WDAT = 4'b0011,
		ST_WSTP = 4'b0100,
		ST_LPW = 4'b0101,
		ST_SUSP = 4'b0110,
		ST_WAKE = 4'b0111,
		ST_RWK = 4'b1000,
		ST_TXK = 4'b1001,
		ST_TXKSTP = 4'b1010,
		ST_WSE0 = 4'b1011,
		ST_HSOPM = 4'b1100,
		ST_PKT = 4'b1101,
		ST_PKTSTP = 4'b1110
	} ulc_state_e;

	// builds a function control byte
	function automatic logic [7:0] ulc_func(logic [1:0] xcvr, logic term,
		logic [1:0] opm, logic suspm);
		logic [7:0] v;
		v = 8'h00;
		v[FUNC_XCVR_LSB +: 2] = xcvr;
		v[FUNC_TERM_BIT] = term;
		v[FUNC_OPM_LSB +: 2] = opm;
		v[FUNC_SUSPM_BIT] = suspm;
		return v;
	endfunction : ulc_func

endpackage : ulc_pkg

// ==== rtl/ulc_rxcmd.sv ====
`timescale 1ns/10ps
module ulc_rxcmd
	import ulc_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ulpi_dir,
	input wire logic ulpi_nxt,
	input wire logic [7:0] ulpi_data_in,
	output logic [1:0] line_state,
	output logic id_level,
	output logic id_changed,
	output logic [1:0] vbus_state,
	output logic vbus_changed
);

	typedef struct packed {
		logic dir_q;
		logic seen;
		logic [1:0] ls;
		logic [1:0] vbus;
		logic id;
		logic id_chg;
		logic vbus_chg;
	} ulc_rx_s;

	ulc_rx_s rx_reg;
	ulc_rx_s rx_next;
	logic rx_valid;

	// a byte with dir high, nxt low and no turnaround is an rxcmd
	assign rx_valid = ulpi_dir && rx_reg.dir_q && !ulpi_nxt;

	// track line state, comparators and id; id and vbus changes give one pulse
	always_comb
	begin
		rx_next = rx_reg;
		rx_next.dir_q = ulpi_dir;
		rx_next.id_chg = 1'b0;
		rx_next.vbus_chg = 1'b0;
		if (rx_valid)
		begin
			rx_next.seen = 1'b1;
			rx_next.ls = ulpi_data_in[RX_LS_LSB +: 2];
			rx_next.vbus = ulpi_data_in[RX_VBUS_LSB +: 2];
			rx_next.id = ulpi_data_in[RX_ID_BIT];
			rx_next.vbus_chg = rx_reg.seen &&
				(ulpi_data_in[RX_VBUS_LSB +: 2] != rx_reg.vbus);
			rx_next.id_chg = rx_reg.seen &&
				(ulpi_data_in[RX_ID_BIT] != rx_reg.id);
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rx_reg <= '0;
		else
			rx_reg <= rx_next;
	end

	assign line_state = rx_reg.ls;
	assign id_level = rx_reg.id;
	assign id_changed = rx_reg.id_chg;
	assign vbus_state = rx_reg.vbus;
	assign vbus_changed = rx_reg.vbus_chg;

endmodule : ulc_rxcmd

// ==== rtl/ulc_timer.sv ====
`timescale 1ns/10ps
module ulc_timer
	import ulc_pkg::*;
#(
	parameter int W = TIMER_W
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic done
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic run;
		logic done;
	} ulc_tmr_s;

	ulc_tmr_s tmr_reg;
	ulc_tmr_s tmr_next;

	// one-shot down counter; a reload restarts it, done pulses once
	always_comb
	begin
		tmr_next = tmr_reg;
		tmr_next.done = 1'b0;
		if (load)
		begin
			tmr_next.cnt = value;
			tmr_next.run = 1'b1;
		end
		else if (tmr_reg.run)
		begin
			if (tmr_reg.cnt <= W'(1))
			begin
				tmr_next.run = 1'b0;
				tmr_next.done = 1'b1;
			end
			else
				tmr_next.cnt = tmr_reg.cnt - W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			tmr_reg <= '0;
		else
			tmr_reg <= tmr_next;
	end

	assign done = tmr_reg.done;

endmodule : ulc_timer

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import ulc_pkg::*;
	logic core_clk = 0, resetn = 0, ulpi_dir, ulpi_nxt, ulpi_stp, ulpi_data_oe;
	logic role_periph = 0, host_powerdown = 0, serial_en = 0, nopid_en = 0;
	logic suspend_req = 0, resume_req = 0, remote_wake_req = 0, tx_start = 0;
	logic slow = 1, rx_go = 0, tx_done, busy, suspended, id_level, id_changed;
	logic vbus_changed;
	logic [7:0] ulpi_data_in, ulpi_data_out, tx_idx, tx_data, rx_byte = 8'h00;
	logic [7:0] tx_len = 8'h04, tx_eop_code = 8'hfe, func_reg, intf_reg, otg_reg;
	logic [7:0] pay [4];
	logic [1:0] line_state, vbus_state, bus_ls = 2'h0;
	int err_count, checks, cyc, eop_kind, pkt_len, k_cyc, res_eop, idc, vbc;
	assign tx_data = pay[tx_idx[1:0]];
	// short counts keep the run small
	ulc_link #(.SUSP_IDLE(20), .HOST_RESUME(40), .RWAKE_DRIVE(10)) DUT (.*);
	ulc_phy_model u_phy (.*);
	always #2 core_clk = ~core_clk;
	// pulse counters and hang guard
	always @(posedge core_clk)
	begin
		idc += id_changed;
		vbc += vbus_changed;
		if (++cyc == 20000)
		begin
			err_count++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic go(input int n);
		repeat (n) @(negedge core_clk);
	endtask : go
	task automatic settle;
		go(2);
		repeat (400) if (busy) go(1);
	endtask : settle
	task automatic rst(input logic per);
		resetn = 0;
		role_periph = per;
		go(2);
		resetn = 1;
		settle();
	endtask : rst
	task automatic rx(input logic [7:0] b);
		rx_byte = b;
		rx_go = 1;
		go(1);
		rx_go = 0;
	endtask : rx
	task automatic t_init;
		rst(0);
		check(otg_reg, 8'h07);
		check(func_reg, 8'h40);
		slow = 0;
		serial_en = 1;
		settle();
		check(intf_reg, 8'h02);
		serial_en = 0;
		settle();
		check(intf_reg, 8'h00);
		$display("test init done");
	endtask : t_init
	task automatic t_pkt;
		nopid_en = 1;
		settle();
		check(func_reg, 8'h58);
		// one sync byte leads each payload
		for (int i = 0; i < 3; i++)
		begin
			pay = '{8'h80, (i == 2) ? 8'ha5 : 8'hc3, 8'h11, 8'h22};
			tx_eop_code = (i == 1) ? 8'h00 : 8'hfe;
			tx_start = 1;
			go(1);
			tx_start = 0;
			repeat (100) if (tx_done !== 1'b1) go(1);
			go(1);
			check(eop_kind, (i == 0) ? 1 : (i == 1) ? 0 : 3);
			check(pkt_len, 4);
		end
		nopid_en = 0;
		settle();
		check(func_reg, 8'h40);
		$display("test packet done");
	endtask : t_pkt
	task automatic t_rx;
		rx(8'h4d);
		go(6);
		check({id_level, vbus_state, line_state}, 5'h1d);
		// the first status after reset sets the baseline, it is no change
		rx(8'h01);
		go(6);
		check({id_level, vbus_state, line_state}, 5'h01);
		check(idc, 1);
		check(vbc, 1);
		$display("test rxcmd done");
	endtask : t_rx
	task automatic t_host;
		suspend_req = 1;
		go(1);
		suspend_req = 0;
		repeat (100) if (suspended !== 1'b1) go(1);
		check(func_reg, 8'h45);
		resume_req = 1;
		go(1);
		resume_req = 0;
		settle();
		check(k_cyc >= 40, 1);
		check(res_eop, 1);
		check(func_reg, 8'h40);
		// powered-down host woken by a peripheral's resume k
		host_powerdown = 1;
		suspend_req = 1;
		go(1);
		suspend_req = 0;
		repeat (100) if (suspended !== 1'b1) go(1);
		check(func_reg, 8'h05);
		bus_ls = LS_RESUME_K;
		settle();
		bus_ls = 2'h0;
		host_powerdown = 0;
		check(k_cyc >= 80, 1);
		check(func_reg, 8'h40);
		$display("test host resume done");
	endtask : t_host
	task automatic t_per;
		rst(1);
		check(otg_reg, 8'h01);
		repeat (200) if (suspended !== 1'b1) go(1);
		check(func_reg, 8'h05);
		bus_ls = LS_RESUME_K;
		rx(8'h00);
		settle();
		// neither se0 nor k, so a stale se0 cannot end the wake-up
		bus_ls = 2'h3;
		check(res_eop, 0);
		check(func_reg, 8'h40);
		repeat (200) if (suspended !== 1'b1) go(1);
		remote_wake_req = 1;
		go(1);
		remote_wake_req = 0;
		repeat (200) if (line_state !== LS_TX_K) go(1);
		check(line_state, LS_TX_K);
		go(20);
		check(func_reg, 8'h55);
		rx(8'h00);
		settle();
		check(k_cyc >= 10, 1);
		check(func_reg, 8'h40);
		$display("test peripheral done");
	endtask : t_per
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	initial
	begin
		t_init();
		t_pkt();
		t_rx();
		t_host();
		t_per();
		wrap_up();
	end
endmodule : tb_top

// ==== test/ulc_link_assertions.sv ====
`timescale 1ns/10ps
// watches the link side of the ulpi bus
module ulc_link_chk
	import ulc_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ulpi_dir,
	input wire logic ulpi_nxt,
	input wire logic ulpi_stp,
	input wire logic [7:0] ulpi_data_out,
	input wire logic ulpi_data_oe,
	input wire logic [7:0] tx_eop_code,
	input wire logic [7:0] tx_idx,
	input wire logic tx_done,
	input wire logic [1:0] line_state,
	input wire logic id_level,
	input wire logic [1:0] vbus_state
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// bus ownership and byte hand-over
	oe_off_a: assert property (ulpi_dir |=> !ulpi_data_oe)
		else $error("link drove during phy turn");
	cmd_hold_a: assert property (ulpi_data_oe && !ulpi_dir && !ulpi_nxt
		&& !ulpi_stp && ulpi_data_out != 8'h00
		|=> ulpi_dir || $stable(ulpi_data_out))
		else $error("byte changed before nxt");
	stp_code_a: assert property (ulpi_stp && ulpi_data_oe && !ulpi_dir
		|-> ulpi_data_out == 8'h00 || ulpi_data_out == tx_eop_code)
		else $error("bad byte beside stp");
	stp_pulse_a: assert property ($rose(ulpi_stp) && ulpi_data_oe
		|=> !ulpi_stp) else $error("stp longer than one cycle");
	done_once_a: assert property (tx_done |=> !tx_done)
		else $error("done held");
	done_why_a: assert property (tx_done |-> $past(ulpi_stp)
		|| $past(ulpi_dir) || $past(ulpi_dir, 2))
		else $error("done without stp or abort");
	idx_step_a: assert property ($changed(tx_idx) && tx_idx != 8'h00
		|-> $past(ulpi_nxt) && tx_idx == $past(tx_idx) + 8'h01)
		else $error("index moved without nxt");
	ls_src_a: assert property ($changed(line_state) && line_state != LS_TX_K
		|-> $past(ulpi_dir) || $past(ulpi_dir, 2)
		|| $past(line_state) == LS_TX_K) else $error("line state unprompted");
	id_src_a: assert property ($changed(id_level)
		|-> $past(ulpi_dir) || $past(ulpi_dir, 2)) else $error("id unprompted");
	vbus_src_a: assert property ($changed(vbus_state)
		|-> $past(ulpi_dir) || $past(ulpi_dir, 2)) else $error("vbus unprompted");
endmodule : ulc_link_chk
bind ulc_link ulc_link_chk u_chk (.*);

// ==== test/ulc_phy_model.sv ====
`timescale 1ns/10ps
// behavioural phy: register file, line endings, rxcmds, low power
module ulc_phy_model
	import ulc_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ulpi_stp,
	input wire logic [7:0] ulpi_data_out,
	input wire logic ulpi_data_oe,
	input wire logic slow,
	input wire logic rx_go,
	input wire logic [7:0] rx_byte,
	input wire logic [1:0] bus_ls,
	output logic ulpi_dir,
	output logic ulpi_nxt,
	output logic [7:0] ulpi_data_in,
	output logic [7:0] func_reg,
	output logic [7:0] intf_reg,
	output logic [7:0] otg_reg,
	output int eop_kind,
	output int pkt_len,
	output int k_cyc,
	output int res_eop
);
	logic act, lp, pend;
	logic [7:0] cmd, dat, pid, rxb;
	int n, w, rxc;
	// one process, so bus effects are ordered by hand, not by the scheduler
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{ulpi_dir, ulpi_nxt, act, lp, pend, func_reg, intf_reg, otg_reg} <= '0;
			{eop_kind, pkt_len, k_cyc, res_eop, rxc} <= '0;
			ulpi_data_in <= 8'h00;
		end
		else
		begin
			ulpi_nxt <= 1'b0;
			if (rx_go)
			begin
				pend = 1;
				rxb = rx_byte;
			end
			if (lp)
			begin
				// low power: phy owns the bus and shows the raw line
				if (ulpi_stp)
					lp = 0;
				ulpi_dir <= lp;
				ulpi_data_in <= {6'h00, bus_ls};
			end
			else if (rxc != 0)
			begin
				// turnaround, then one status byte
				ulpi_data_in <= (rxc == 1) ? rxb : ~rxb;
				ulpi_dir <= (rxc == 1);
				rxc = (rxc == 1) ? 2 : 0;
			end
			else if (ulpi_stp && act)
			begin
				act = 0;
				pkt_len = n - 1;
				if (cmd[7:6] == TXCMD_REGWR)
				begin
					// serial mode bit sits in interface control
					if (cmd[5:0] == ADDR_FUNC)
						func_reg = dat;
					if (cmd[5:0] == ADDR_INTF)
						intf_reg = dat;
					if (cmd[5:0] == ADDR_OTG)
						otg_reg = dat;
					lp = cmd[5:0] == ADDR_FUNC && !dat[FUNC_SUSPM_BIT];
					ulpi_dir <= lp;
				end
				else if (func_reg[4:3] == OPM_NO_SYNC_EOP)
					// stp byte and pid choose the ending
					eop_kind = (cmd != TXCMD_NOPID) ? 9 : (ulpi_data_out == 8'h00)
						? 0 : (pid == 8'ha5) ? 3 : (ulpi_data_out == 8'hfe) ? 1 : 2;
				else if (func_reg[4:3] == OPM_NO_BITSTUFF && otg_reg[2:1] == 2'h3)
				begin
					// only a host gets the resume eop, then se0
					res_eop = 1;
					pend = 1;
					rxb = 8'h00;
				end
			end
			else if (!ulpi_dir && ulpi_data_oe && (act || ulpi_data_out != 8'h00))
			begin
				if (!act)
				begin
					act = 1;
					cmd = ulpi_data_out;
					n = 0;
					w = 0;
				end
				if (ulpi_nxt)
				begin
					n++;
					w = 0;
					if (n == 2)
						dat = ulpi_data_out;
					if (n == 3)
						pid = ulpi_data_out;
				end
				if (func_reg[4:3] == OPM_NO_BITSTUFF)
					k_cyc++;
				// slow mode holds each byte two extra cycles
				ulpi_nxt <= !ulpi_nxt && w++ >= (slow ? 2 : 0);
			end
			else if (pend && !act && !ulpi_stp && ulpi_data_out == 8'h00)
			begin
				pend = 0;
				rxc = 1;
				ulpi_dir <= 1'b1;
				ulpi_data_in <= ~ulpi_data_in;
			end
			else
				ulpi_data_in <= ~ulpi_data_in; // released bus keeps moving
		end
	end
endmodule : ulc_phy_model
